// *** hdl/cpm_map.vh ***
/*
  Constants for the configuration pin mode multiplexer: mode codes, width codes,
  mode class bit positions, state codes, pin group masks and bit positions.
  Assumes it is included by its bare name from every design file that needs it.
*/
`ifndef CPM_MAP_VH
`define CPM_MAP_VH

// Three-bit mode select codes.
`define CPM_MODE_MSER   3'h0
`define CPM_MODE_SPI    3'h1
`define CPM_MODE_PFL    3'h2
`define CPM_MODE_MPP    3'h4
`define CPM_MODE_JTAG   3'h5
`define CPM_MODE_SPP    3'h6
`define CPM_MODE_SSER   3'h7

// One-hot mode class bit positions.
`define CPM_C_JTAG      0
`define CPM_C_SPI       1
`define CPM_C_SSER      2
`define CPM_C_MSER      3
`define CPM_C_PFL       4
`define CPM_C_MPP       5
`define CPM_C_SPP       6
`define CPM_CLASS_W     7

// Serial flash width codes.
`define CPM_SW_X1       2'h0
`define CPM_SW_X2       2'h1
`define CPM_SW_X4       2'h2
`define CPM_SW_DUAL     2'h3

// Parallel width codes.
`define CPM_PW_X8       2'h0
`define CPM_PW_X16      2'h1
`define CPM_PW_X32      2'h2

// One-hot sequencer states.
`define CPM_ST_IDLE     3'h1
`define CPM_ST_CFG      3'h2
`define CPM_ST_USER     3'h4

// Data pin masks; bits 3:0 sit in bank 0, bits 15:4 in bank 65.
`define CPM_DM_NONE     16'h0000
`define CPM_DM_D0       16'h0001
`define CPM_DM_D1       16'h0002
`define CPM_DM_D10      16'h0003
`define CPM_DM_D30      16'h000f
`define CPM_DM_D70      16'h00ff
`define CPM_DM_D150     16'hffff

// Bit positions inside the single-pin group.
`define CPM_M_RWFS      0
`define CPM_M_SAV       1
`define CPM_M_CHAIN     2
`define CPM_M_OEN       3
`define CPM_M_WSS       4
`define CPM_M_RS0       5
`define CPM_M_RS1       6
`define CPM_M_EMC       7
`define CPM_MISC_W      8

`endif

// *** hdl/cpm_mode_decode.v ***
/*
  Decodes the latched three-bit mode select into a one-hot mode class and a
  master flag. Assumes the mode value is already held stable by its owner.
*/
`include "cpm_map.vh"

module cpm_mode_decode (
  input  wire [2:0]               mode,
  output reg  [`CPM_CLASS_W-1:0]  mode_class,
  output reg                      is_master
);

  ////////////////////////////////////////////////////////////////////////////
  // Code 011 is not a defined mode, so it maps to no class and no pin use.
  always @* begin
    mode_class = {`CPM_CLASS_W{1'b0}};
    is_master  = 1'b0;
    case (mode)
      `CPM_MODE_JTAG: begin
        mode_class[`CPM_C_JTAG] = 1'b1;
      end
      `CPM_MODE_SPI: begin
        mode_class[`CPM_C_SPI] = 1'b1;
        is_master              = 1'b1;
      end
      `CPM_MODE_SSER: begin
        mode_class[`CPM_C_SSER] = 1'b1;
      end
      `CPM_MODE_MSER: begin
        mode_class[`CPM_C_MSER] = 1'b1;
        is_master               = 1'b1;
      end
      `CPM_MODE_PFL: begin
        mode_class[`CPM_C_PFL] = 1'b1;
        is_master              = 1'b1;
      end
      `CPM_MODE_MPP: begin
        mode_class[`CPM_C_MPP] = 1'b1;
        is_master              = 1'b1;
      end
      `CPM_MODE_SPP: begin
        mode_class[`CPM_C_SPP] = 1'b1;
      end
      default: begin
        mode_class = {`CPM_CLASS_W{1'b0}};
      end
    endcase
  end

endmodule // cpm_mode_decode

// *** hdl/cpm_pin_reg.v ***
/*
  One registered group of pins: drive value, output enable and masked input.
  Assumes the enclosing logic computes enables and masks; the pad resolves
  the wire level from the enable outside this module.
*/

module cpm_pin_reg #(
  parameter W = 8
) (
  input  wire         mclk,
  input  wire         reset_n,
  input  wire [W-1:0] drive_val,
  input  wire [W-1:0] drive_en,
  input  wire [W-1:0] pin_in,
  input  wire [W-1:0] in_mask,
  output reg  [W-1:0] pin_out_q,
  output reg  [W-1:0] pin_oe_q,
  output reg  [W-1:0] core_in_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Undriven bits output zero so an idle pad never toggles its data path.
  // Masked inputs read zero, so a floating unused pin cannot reach the core.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_q <= {W{1'b0}};
      pin_oe_q  <= {W{1'b0}};
      core_in_q <= {W{1'b0}};
    end else begin
      pin_out_q <= drive_val & drive_en;
      pin_oe_q  <= drive_en;
      core_in_q <= pin_in & in_mask;
    end
  end

endmodule // cpm_pin_reg

// *** hdl/cpm_config_pin_mode_mux.v ***
/*
  Configuration pin mode multiplexer: assigns functions to the configuration
  pins from the mode latched at the start of each configuration attempt.
  Assumes all inputs are synchronous to mclk and that reset_n is the program
  pin. Two-way pins are split into input, output and output enable.
*/
`include "cpm_map.vh"

module cpm_config_pin_mode_mux (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        cfg_start,
  input  wire        cfg_done,
  input  wire [2:0]  mode_pins,
  input  wire [1:0]  serial_width,
  input  wire [1:0]  parallel_width,
  input  wire        persist_en,
  input  wire        daisy_chain_en,
  input  wire        debug_bitstream_en,
  input  wire        ext_clk_en,
  input  wire        multi_image_reboot,
  input  wire        fallback_en,
  input  wire        fallback_event,
  input  wire        jtag_request,
  input  wire        flash_chip_select_n,
  input  wire        second_flash_select_n,
  input  wire [31:0] data_drive,
  input  wire        data_drive_en,
  input  wire [28:0] address_out,
  input  wire        address_valid_n,
  input  wire        flash_output_enable_n,
  input  wire        flash_write_enable_n,
  input  wire        chain_serial_out,
  input  wire        chain_chip_enable_n,
  input  wire [1:0]  revision_select_value,
  input  wire [15:0] data_pin_in,
  input  wire [15:0] addr_data_pin_in,
  input  wire        rw_or_flash_select_pin_in,
  input  wire        select_or_addr_valid_pin_in,
  input  wire        external_master_clock_in,
  output wire [15:0] data_pin_out_q,
  output wire [15:0] data_pin_oe_q,
  output wire [28:0] addr_pin_out_q,
  output wire [28:0] addr_pin_oe_q,
  output wire [7:0]  misc_pin_out_q,
  output wire [7:0]  misc_pin_oe_q,
  output wire [31:0] data_in_q,
  output wire        read_write_direction_n_q,
  output wire        chip_select_in_n_q,
  output wire        ext_clock_q,
  output reg         ext_clock_used_q,
  output reg         config_active_q,
  output reg         pins_released_q,
  output reg  [2:0]  mode_q,
  output reg         jtag_grant_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Latched configuration and state.
  reg  [2:0]              state_q;       // One-hot sequencer state.
  reg  [2:0]              state_d;       // Next sequencer state.
  reg  [1:0]              sw_q;          // Latched serial width.
  reg  [1:0]              pw_q;          // Latched parallel width.
  reg                     persist_q;     // Latched keep-pins option.
  reg                     daisy_q;       // Latched daisy-chain use.
  reg                     debug_q;       // Latched debug bitstream option.
  reg                     ext_en_q;      // Latched external clock option.
  reg                     rev_drive_q;   // Revision outputs being driven.
  wire [`CPM_CLASS_W-1:0] cls;           // Decoded class of mode_q.
  wire                    is_master;     // Mode_q is a master mode.
  wire [7:0]              misc_in;       // Masked single-pin inputs.
  wire [28:0]             addr_in;       // Masked address-pad inputs; 15:0 carry data.

  // Combinational pin drive, enable and input masks.
  reg  [15:0] d_val;
  reg  [15:0] d_en;
  reg  [15:0] d_msk;
  reg  [28:0] a_val;
  reg  [28:0] a_en;
  reg  [28:0] a_msk;
  reg  [7:0]  m_val;
  reg  [7:0]  m_en;
  reg  [7:0]  m_msk;
  reg  [15:0] used;
  reg  [15:0] force_out;
  reg  [15:0] in_only;
  reg         act;
  reg         ser_chain;
  reg         par_group;
  wire        rev_event;

  ////////////////////////////////////////////////////////////////////////////
  // Data lines used by a mode. Every data mode uses part of bank 0 lines 3:0;
  // bank 65 lines 15:4 are enabled only by the modes that need them.
  function [15:0] data_used;
    input [`CPM_CLASS_W-1:0] c;
    input [1:0]              sw;
    input [1:0]              pw;
    begin
      data_used = `CPM_DM_NONE;
      if (c[`CPM_C_SPI]) begin
        case (sw)
          `CPM_SW_X1, `CPM_SW_X2: data_used = `CPM_DM_D10;
          `CPM_SW_X4:   data_used = `CPM_DM_D30;
          `CPM_SW_DUAL: data_used = `CPM_DM_D70;
          default:      data_used = `CPM_DM_NONE;
        endcase
      end else if (c[`CPM_C_SSER] | c[`CPM_C_MSER]) begin
        data_used = `CPM_DM_D1;
      end else if (c[`CPM_C_PFL] | c[`CPM_C_MPP] | c[`CPM_C_SPP]) begin
        data_used = (pw == `CPM_PW_X8) ? `CPM_DM_D70 : `CPM_DM_D150;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode class of the latched mode; the live pins never reach the mux.
  cpm_mode_decode u_decode (
    .mode       (mode_q),
    .mode_class (cls),
    .is_master  (is_master)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: a new start may come from any state and restarts the attempt.
  always @* begin
    state_d = state_q;
    case (state_q)
      `CPM_ST_IDLE, `CPM_ST_USER: begin
        if (cfg_start) begin
          state_d = `CPM_ST_CFG;
        end
      end
      `CPM_ST_CFG: begin
        if (cfg_done & ~cfg_start) begin
          state_d = `CPM_ST_USER;
        end
      end
      default: begin
        state_d = `CPM_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Options are latched with the mode so that a change on the live inputs
  // mid-attempt cannot tear the pin assignment apart.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= `CPM_ST_IDLE;
      mode_q    <= `CPM_MODE_SSER;
      sw_q      <= `CPM_SW_X1;
      pw_q      <= `CPM_PW_X8;
      persist_q <= 1'b0;
      daisy_q   <= 1'b0;
      debug_q   <= 1'b0;
      ext_en_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (cfg_start) begin
        mode_q    <= mode_pins;
        sw_q      <= serial_width;
        pw_q      <= parallel_width;
        persist_q <= persist_en;
        daisy_q   <= daisy_chain_en;
        debug_q   <= debug_bitstream_en;
        ext_en_q  <= ext_clk_en;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Revision outputs: set by a reboot or an enabled fallback in parallel
  // flash mode, dropped when the next configuration completes or a start latches another mode. Set wins.
  assign rev_event = cls[`CPM_C_PFL] & ~state_q[0] &
                     (multi_image_reboot | (fallback_en & fallback_event));

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rev_drive_q <= 1'b0;
    end else if (rev_event) begin
      rev_drive_q <= 1'b1;
    end else if (cfg_done | ~cls[`CPM_C_PFL]) begin
      rev_drive_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and JTAG. JTAG access follows its request alone, never the mode.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      config_active_q  <= 1'b0;
      pins_released_q  <= 1'b0;
      jtag_grant_q     <= 1'b0;
      ext_clock_used_q <= 1'b0;
    end else begin
      config_active_q  <= state_d[1];
      pins_released_q  <= state_d[2] & ~persist_q;
      jtag_grant_q     <= jtag_request;
      ext_clock_used_q <= is_master & ext_en_q & ~state_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin function mux. Everything starts undriven and masked, so any pin that
  // no branch claims stays high-impedance with its input ignored.
  always @* begin
    d_val     = 16'h0000;
    d_en      = 16'h0000;
    d_msk     = 16'h0000;
    a_val     = 29'h0000_0000;
    a_en      = 29'h0000_0000;
    a_msk     = 29'h0000_0000;
    m_val     = 8'h00;
    m_en      = 8'h00;
    m_msk     = 8'h00;
    used      = data_used(cls, sw_q, pw_q);
    ser_chain = (cls[`CPM_C_SPI] & (sw_q == `CPM_SW_X1)) |
                cls[`CPM_C_SSER] | cls[`CPM_C_MSER];
    par_group = cls[`CPM_C_PFL] | cls[`CPM_C_MPP] | cls[`CPM_C_SPP];
    // Pins work during an attempt, and afterwards only with persist.
    act = state_q[1] | (state_q[2] & persist_q);
    force_out = {15'h0000, cls[`CPM_C_SPI] & (sw_q == `CPM_SW_X1)};
    in_only   = {14'h0000, ser_chain, 1'b0};
    if (act) begin
      // Data lines: forced outputs, input-only lines, or core-steered.
      d_val = data_drive[15:0];
      d_en  = used & (force_out | ({16{data_drive_en}} & ~in_only));
      d_msk = used & ~force_out;
      // Shared flash select / read-write pin in bank 0.
      if (cls[`CPM_C_SPI] | cls[`CPM_C_PFL]) begin
        m_val[`CPM_M_RWFS] = flash_chip_select_n;
        m_en[`CPM_M_RWFS]  = 1'b1;
      end else if (cls[`CPM_C_MPP] | cls[`CPM_C_SPP]) begin
        m_msk[`CPM_M_RWFS] = 1'b1;
        m_msk[`CPM_M_SAV]  = 1'b1;
      end
      // Address and upper data lines.
      if (cls[`CPM_C_PFL]) begin
        a_val = address_out;
        a_en  = {29{1'b1}};
        m_val[`CPM_M_SAV] = address_valid_n;
        m_en[`CPM_M_SAV]  = 1'b1;
        m_val[`CPM_M_WSS:`CPM_M_OEN] = {flash_write_enable_n, flash_output_enable_n};
        m_en[`CPM_M_WSS:`CPM_M_OEN]  = 2'h3;
      end else if (cls[`CPM_C_SPP] & (pw_q == `CPM_PW_X32)) begin
        a_val[15:0] = data_drive[31:16];
        a_en[15:0]  = {16{data_drive_en}};
        a_msk[15:0] = 16'hffff;
      end
      if (cls[`CPM_C_SPI] & (sw_q == `CPM_SW_DUAL)) begin
        m_val[`CPM_M_WSS] = second_flash_select_n;
        m_en[`CPM_M_WSS]  = 1'b1;
      end
      // Shared chain pin: serial data or downstream chip enable.
      if (ser_chain & (daisy_q | debug_q)) begin
        m_val[`CPM_M_CHAIN] = chain_serial_out;
        m_en[`CPM_M_CHAIN]  = 1'b1;
      end else if (par_group & daisy_q) begin
        m_val[`CPM_M_CHAIN] = chain_chip_enable_n;
        m_en[`CPM_M_CHAIN]  = 1'b1;
      end
    end
    // Revision outputs may drive after the attempt, even without persist,
    // because a reboot is requested from user mode.
    if (rev_drive_q) begin
      m_val[`CPM_M_RS1:`CPM_M_RS0] = revision_select_value;
      m_en[`CPM_M_RS1:`CPM_M_RS0]  = 2'h3;
    end
    // External clock is only an input, and only for master modes.
    m_msk[`CPM_M_EMC] = is_master & ext_en_q & ~state_q[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin groups; every pad output comes from a flip-flop here.
  cpm_pin_reg #(.W(16)) u_data (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .drive_val (d_val),
    .drive_en  (d_en),
    .pin_in    (data_pin_in),
    .in_mask   (d_msk),
    .pin_out_q (data_pin_out_q),
    .pin_oe_q  (data_pin_oe_q),
    .core_in_q (data_in_q[15:0])
  );

  cpm_pin_reg #(.W(29)) u_addr (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .drive_val (a_val),
    .drive_en  (a_en),
    .pin_in    ({13'h0000, addr_data_pin_in}),
    .in_mask   (a_msk),
    .pin_out_q (addr_pin_out_q),
    .pin_oe_q  (addr_pin_oe_q),
    .core_in_q (addr_in)
  );

  cpm_pin_reg #(.W(`CPM_MISC_W)) u_misc (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .drive_val (m_val),
    .drive_en  (m_en),
    .pin_in    ({external_master_clock_in, 5'h00, select_or_addr_valid_pin_in,
                 rw_or_flash_select_pin_in}),
    .in_mask   (m_msk),
    .pin_out_q (misc_pin_out_q),
    .pin_oe_q  (misc_pin_oe_q),
    .core_in_q (misc_in)
  );

  // Masked inputs read zero, so an ignored active-low strobe looks asserted.
  assign data_in_q[31:16]         = addr_in[15:0];
  assign read_write_direction_n_q = misc_in[`CPM_M_RWFS];
  assign chip_select_in_n_q       = misc_in[`CPM_M_SAV];
  assign ext_clock_q              = misc_in[`CPM_M_EMC];

endmodule // cpm_config_pin_mode_mux

// *** verification/cpm_chk_chk.sv ***
/*
  Checker for the configuration pin mode multiplexer, bound to its top module.
  Assumes mclk is the only clock and reset_n the asynchronous program reset.
*/
`include "cpm_map.vh"

module cpm_chk (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        cfg_start,
  input wire logic        cfg_done,
  input wire logic [2:0]  mode_pins,
  input wire logic        multi_image_reboot,
  input wire logic        jtag_request,
  input wire logic [15:0] data_pin_oe_q,
  input wire logic [28:0] addr_pin_oe_q,
  input wire logic [7:0]  misc_pin_oe_q,
  input wire logic [31:0] data_in_q,
  input wire logic        ext_clock_q,
  input wire logic        config_active_q,
  input wire logic [2:0]  mode_q,
  input wire logic        jtag_grant_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // A cycle with neither start nor done, so a pending change is not overtaken.
  sequence s_quiet;
    !cfg_start && !cfg_done;
  endsequence
  sequence s_pfl_go;
    cfg_start && mode_pins == `CPM_MODE_PFL ##1 s_quiet;
  endsequence
  sequence s_boot;
    config_active_q && mode_q == `CPM_MODE_PFL && multi_image_reboot && !cfg_start ##1 s_quiet;
  endsequence

  AST_MODE_LATCH: assert property (cfg_start |=> mode_q == $past(mode_pins) && config_active_q)
    else $error("mode not latched on start");
  AST_MODE_HOLD: assert property (!cfg_start |=> $stable(mode_q))
    else $error("mode changed without start");
  AST_PFL_ADDR: assert property (s_pfl_go |=> addr_pin_oe_q == 29'h1fff_ffff && misc_pin_oe_q[1:0] == 2'b11)
    else $error("flash address pins not driven");
  AST_ADDR_ONLY: assert property (|addr_pin_oe_q |-> $past(mode_q) inside {`CPM_MODE_PFL, `CPM_MODE_SPP})
    else $error("address pins driven in wrong mode");
  AST_REV_START: assert property (s_boot |=> misc_pin_oe_q[6:5] == 2'b11)
    else $error("revision outputs not driven");
  AST_REV_ONLY: assert property (|misc_pin_oe_q[6:5] |-> $past(mode_q, 2) == `CPM_MODE_PFL)
    else $error("revision outputs driven outside flash mode");
  AST_JTAG_GRANT: assert property (1 |=> jtag_grant_q == $past(jtag_request))
    else $error("jtag grant does not follow request");
  AST_JTAG_QUIET: assert property ($past(mode_q) == `CPM_MODE_JTAG && mode_q == `CPM_MODE_JTAG
    |-> data_pin_oe_q == 16'h0000 && misc_pin_oe_q == 8'h00 && data_in_q == 32'h0000_0000)
    else $error("pins active in jtag only mode");
  AST_DONE_ENDS: assert property (cfg_done && config_active_q && !cfg_start |=> !config_active_q)
    else $error("done did not end configuration");
  AST_EXT_CLK: assert property (ext_clock_q |-> mode_q inside {0, 1, 2, 4} || $past(mode_q) inside {0, 1, 2, 4})
    else $error("external clock used in slave mode");
  AST_UPPER_LANE: assert property (|data_in_q[31:16] |-> mode_q == `CPM_MODE_SPP || $past(mode_q) == `CPM_MODE_SPP)
    else $error("upper data lane read outside slave port");
endmodule // cpm_chk

bind cpm_config_pin_mode_mux cpm_chk u_chk (.mclk(mclk), .reset_n(reset_n), .cfg_start(cfg_start),
  .cfg_done(cfg_done), .mode_pins(mode_pins), .multi_image_reboot(multi_image_reboot),
  .jtag_request(jtag_request), .data_pin_oe_q(data_pin_oe_q), .addr_pin_oe_q(addr_pin_oe_q),
  .misc_pin_oe_q(misc_pin_oe_q), .data_in_q(data_in_q), .ext_clock_q(ext_clock_q),
  .config_active_q(config_active_q), .mode_q(mode_q), .jtag_grant_q(jtag_grant_q));

// *** verification/cpm_far_model.sv ***
/*
  Far-side model: flash or host pads and an external master clock source.
  Assumes the device's enables are high while it drives a pad.
*/
module cpm_far_model (
  input  wire logic        mclk,
  input  wire logic [15:0] d_out,
  input  wire logic [15:0] d_oe,
  input  wire logic [28:0] a_out,
  input  wire logic [28:0] a_oe,
  input  wire logic        host_rd,
  input  wire logic        host_sel,
  input  wire logic        clk_run,
  output logic      [15:0] d_in,
  output logic      [15:0] a_in,
  output logic             rw_pin,
  output logic             sel_pin_n,
  output logic             emc
);
  timeunit 1ns;
  timeprecision 1ps;
  // Where the device does not drive, the far side shows its own pattern.
  assign d_in = (d_oe & d_out) | (~d_oe & 16'h5a5a);
  assign a_in = (a_oe[15:0] & a_out[15:0]) | (~a_oe[15:0] & 16'h3c3c);
  assign rw_pin = host_rd;
  assign sel_pin_n = ~host_sel;
  initial emc = 1'b0;
  // Clock stands still unless a scenario runs it; toggled away from mclk rises.
  always @(negedge mclk) begin
    if (clk_run) emc <= ~emc;
  end
endmodule // cpm_far_model

// *** verification/tb.sv ***
/*
  Self-checking bench for the configuration pin mode multiplexer.
  Assumes the far-side model resolves the data and address pads from the device enables.
*/
`include "cpm_map.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset_n = 0, st = 0, dn = 0, per = 0, dch = 0, dbg = 0, xce = 0;
  logic rbt = 0, fbe = 0, fbv = 0, jrq = 0, dde = 0, crun = 0;
  logic [2:0] md = 0;
  logic [1:0] sw = 0, pw = 0;
  logic [31:0] cv = 32'h1234_abcd;
  wire [15:0] dpo, dpe, dpi, api;
  wire [28:0] apo, ape;
  wire [7:0] mpo, mpe;
  wire [31:0] din;
  wire [2:0] mq;
  wire rwn, csn, xcq, xcu, act, rel, jg, rwp, svp, emc;
  int miscompares = 0, comparisons = 0;

  always #2.5 mclk = ~mclk;

  cpm_config_pin_mode_mux DUT (.mclk(mclk), .reset_n(reset_n), .cfg_start(st), .cfg_done(dn),
    .mode_pins(md), .serial_width(sw), .parallel_width(pw), .persist_en(per),
    .daisy_chain_en(dch), .debug_bitstream_en(dbg), .ext_clk_en(xce), .multi_image_reboot(rbt),
    .fallback_en(fbe), .fallback_event(fbv), .jtag_request(jrq), .flash_chip_select_n(cv[0]),
    .second_flash_select_n(cv[1]), .data_drive(cv), .data_drive_en(dde),
    .address_out(cv[28:0]), .address_valid_n(cv[3]), .flash_output_enable_n(cv[6]),
    .flash_write_enable_n(cv[7]), .chain_serial_out(cv[2]), .chain_chip_enable_n(cv[1]),
    .revision_select_value(cv[5:4]), .data_pin_in(dpi), .addr_data_pin_in(api),
    .rw_or_flash_select_pin_in(rwp), .select_or_addr_valid_pin_in(svp),
    .external_master_clock_in(emc), .data_pin_out_q(dpo), .data_pin_oe_q(dpe),
    .addr_pin_out_q(apo), .addr_pin_oe_q(ape), .misc_pin_out_q(mpo), .misc_pin_oe_q(mpe),
    .data_in_q(din), .read_write_direction_n_q(rwn), .chip_select_in_n_q(csn),
    .ext_clock_q(xcq), .ext_clock_used_q(xcu), .config_active_q(act), .pins_released_q(rel),
    .mode_q(mq), .jtag_grant_q(jg));

  cpm_far_model u_far (.mclk(mclk), .d_out(dpo), .d_oe(dpe), .a_out(apo), .a_oe(ape),
    .host_rd(1'b1), .host_sel(1'b0), .clk_run(crun), .d_in(dpi), .a_in(api),
    .rw_pin(rwp), .sel_pin_n(svp), .emc(emc));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared steps; each one that waits ends on a falling edge once outputs have settled.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Pins follow a start one rising edge after the edge that takes it.
  task automatic start(input logic [2:0] m, input logic [1:0] s, input logic [1:0] p);
    md = m;
    sw = s;
    pw = p;
    st = 1;
    @(negedge mclk);
    st = 0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic finish_cfg;
    dn = 1;
    @(negedge mclk);
    dn = 0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic pulse_ev(input bit boot);
    if (boot) rbt = 1;
    else fbv = 1;
    @(negedge mclk);
    rbt = 0;
    fbv = 0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic seen(input logic e);
    logic s;
    s = 0;
    repeat (8) begin
      @(negedge mclk);
      s = s | xcq;
    end
    chk(s, e, "ext clock");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      jrq = i[0];
      start(i[2:0], 2'h0, 2'h0);
      chk(mq, i, "mode code");
      chk(jg, i[0], "jtag grant");
      if (i == 5 || i == 3) chk(|{dpe, mpe, ape}, 0, "quiet mode");
    end
    jrq = 0;
  endtask
  task automatic t_ser;
    logic [15:0] dm [4] = '{16'h0001, 16'h0003, 16'h000f, 16'h00ff};
    dde = 1;
    for (int s = 0; s < 4; s++) begin
      start(`CPM_MODE_SPI, s[1:0], 2'h0);
      chk(dpe, dm[s], "flash data oe");
      chk(mpe, s == 3 ? 8'h11 : 8'h01, "flash select oe");
      chk(dpo & dm[s], cv[15:0] & dm[s], "flash data out");
    end
    for (int k = 0; k < 2; k++) begin
      start(k ? `CPM_MODE_MSER : `CPM_MODE_SSER, 2'h0, 2'h0);
      chk(|{dpe, mpe, ape}, 0, "serial oe");
      chk(din, 32'h0000_0002, "serial data in");
    end
    dde = 0;
  endtask
  task automatic t_par;
    logic [2:0] ml [3] = '{`CPM_MODE_PFL, `CPM_MODE_MPP, `CPM_MODE_SPP};
    logic f;
    cv = 32'h0fed_5432;
    for (int i = 0; i < 3; i++) begin
      for (int p = 0; p < 3; p++) begin
        start(ml[i], 2'h0, p[1:0]);
        f = (ml[i] == `CPM_MODE_PFL);
        chk(din[15:0], 16'h5a5a & (p == 0 ? 16'h00ff : 16'hffff), "parallel data in");
        if (!(i == 2 && p == 2)) chk(din[31:16], 0, "upper lane");
        else chk(din[31:16], 16'h3c3c, "upper lane in");
        chk(ape, f ? 29'h1fff_ffff : 29'h0, "address oe");
        chk(mpe, f ? 8'h1b : 8'h00, "control oe");
        chk({rwn, csn}, f ? 2'b00 : 2'b11, "direction and select in");
        if (f) chk({apo, mpo[0]}, {cv[28:0], cv[0]}, "address out");
      end
    end
  endtask
  task automatic t_chain;
    dch = 1;
    start(`CPM_MODE_SPI, 2'h0, 2'h0);
    chk({mpe[2], mpo[2]}, {1'b1, cv[2]}, "chain data");
    start(`CPM_MODE_SPI, 2'h2, 2'h0);
    chk(mpe[2], 0, "chain off at x4");
    start(`CPM_MODE_PFL, 2'h0, 2'h0);
    chk({mpe[2], mpo[2]}, {1'b1, cv[1]}, "chain enable");
    dch = 0;
    start(`CPM_MODE_PFL, 2'h0, 2'h0);
    chk(mpe[2], 0, "chain enable off");
    dbg = 1;
    start(`CPM_MODE_SSER, 2'h0, 2'h0);
    chk(mpe[2], 1, "debug chain");
    dbg = 0;
  endtask
  task automatic t_rev;
    start(`CPM_MODE_PFL, 2'h1, 2'h1);
    md = `CPM_MODE_JTAG;
    pulse_ev(0);
    chk(mpe[6:5], 0, "fallback disabled");
    chk(mq, `CPM_MODE_PFL, "mode held");
    pulse_ev(1);
    chk({mpe[6:5], mpo[6:5]}, {2'b11, cv[5:4]}, "reboot drive");
    finish_cfg();
    chk(mpe[6:5], 0, "revision released");
    fbe = 1;
    start(`CPM_MODE_PFL, 2'h0, 2'h0);
    pulse_ev(0);
    chk(mpe[6:5], 2'b11, "fallback drive");
    start(`CPM_MODE_SPI, 2'h0, 2'h0);
    pulse_ev(1);
    chk(mpe[6:5], 0, "no revision in flash serial");
    fbe = 0;
  endtask
  task automatic t_persist;
    dde = 1;
    start(`CPM_MODE_SPI, 2'h2, 2'h0);
    finish_cfg();
    chk({act, rel, dpe}, {2'b01, 16'h0000}, "pins released");
    per = 1;
    start(`CPM_MODE_SPI, 2'h2, 2'h0);
    finish_cfg();
    chk({act, rel, dpe}, {2'b00, 16'h000f}, "pins kept");
    per = 0;
    dde = 0;
  endtask
  task automatic t_ext;
    crun = 1;
    xce = 1;
    start(`CPM_MODE_MSER, 2'h0, 2'h0);
    chk(xcu, 1, "ext clock used");
    seen(1);
    start(`CPM_MODE_SSER, 2'h0, 2'h0);
    seen(0);
    xce = 0;
    start(`CPM_MODE_MSER, 2'h0, 2'h0);
    chk(xcu, 0, "ext clock unused");
    seen(0);
    crun = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (10) @(negedge mclk);
    reset_n = 1;
    t_codes();
    t_ser();
    t_par();
    t_chain();
    t_rev();
    t_persist();
    t_ext();
    end_sim();
  end
endmodule // tb
